// File: bench/smb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module smb_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output var logic [7:0] regAddr = 8'h00,
    output var logic regWrEn = 1'h0,
    output var logic [7:0] regWrData = 8'h00,
    // Bus lines, released high, and abort request, idle low
    output var logic scl = 1'h1,
    output var logic sda = 1'h1,
    output var logic foreignAbort = 1'h0
);
    // Single byte write, strobe held over one edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        @(negedge clk);
        regWrEn = 1'h0;
        regWrData = ~d;
    endtask
    // Address select for a combinational read
    task sel(input logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        #1;
    endtask
    // Line levels
    task lines(input logic c, input logic d);
        @(negedge clk);
        scl = c;
        sda = d;
    endtask
    task abort;
        @(negedge clk);
        foreignAbort = 1'h1;
        @(negedge clk);
        foreignAbort = 1'h0;
    endtask
    task stop;
        lines(1'h1, 1'h0);
        lines(1'h1, 1'h1);
    endtask
endmodule
`default_nettype wire

// File: bench/touch_global_config_chk.sv
`timescale 1ns/10ps
`default_nettype none
module touch_global_config_chk #(
    parameter NCH = 14,
    parameter MS_CYCLES = 125000,
    parameter IDLE_CYCLES = 18750
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // Bus lines and watchdog
    input wire logic scl,
    input wire logic sda,
    input wire logic deepSleep,
    input wire logic foreignAbort,
    input wire logic busTimeout,
    input wire logic busIdleReset,
    input wire logic busIgnore,
    // Detection
    input wire logic [NCH-1:0] lfNoise,
    input wire logic [NCH-1:0] aboveNoise,
    input wire logic [NCH-1:0] touchDetect,
    input wire logic [NCH-1:0] calRetry,
    input wire logic [NCH-1:0] recalExclude,
    // Button tracker
    input wire logic buttonPressed,
    input wire logic buttonIrq,
    input wire logic buttonRecal
);
    logic [7:0] ctrlSh;
    logic [31:0] lowCnt;
    logic [15:0] highCnt;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // Control shadow and run lengths of the line levels
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlSh <= 8'h29;
            lowCnt <= 32'h0;
            highCnt <= 16'h0000;
        end else begin
            if (regWrEn && regAddr == 8'h20) begin
                ctrlSh <= regWrData;
            end
            lowCnt <= scl ? 32'h0 : lowCnt + 32'h1;
            highCnt <= (scl && sda) ? highCnt + 16'h0001 : 16'h0000;
        end
    end
    // Write then read back on the same address
    sequence ctrlWrite;
        regWrEn && regAddr == 8'h20 ##1 regAddr == 8'h20;
    endsequence
    sens_bit7_a: assert property (regAddr == 8'h1F |-> !regRdData[7])
        else $error("sensitivity bit 7 reads one");
    unmapped_read_a: assert property (regAddr != 8'h1F && regAddr != 8'h20 |-> regRdData == 8'h00)
        else $error("unmapped read not zero");
    ctrl_write_a: assert property (ctrlWrite |-> regRdData == $past(regWrData))
        else $error("control write not taken");
    timeout_cause_a: assert property (busTimeout |-> ctrlSh[7] && lowCnt >= 30 * MS_CYCLES)
        else $error("timeout without cause");
    idle_cause_a: assert property (busIdleReset |-> ctrlSh[7] && !$past(deepSleep) && highCnt >= IDLE_CYCLES)
        else $error("idle reset without cause");
    ignore_set_a: assert property ($rose(busIgnore) |-> $past(foreignAbort) && $past(deepSleep))
        else $error("ignore set without abort");
    press_irq_a: assert property ($rose(buttonPressed) |=> buttonIrq)
        else $error("no interrupt on press");
    recal_cause_a: assert property (buttonRecal |-> $past(buttonPressed) && $past(ctrlSh[3]))
        else $error("recalibration without held press");
    noise_block_a: assert property (lfNoise[0] && !ctrlSh[4] |=> !touchDetect[0] && calRetry[0])
        else $error("noise did not block touch");
    noise_exclude_a: assert property (!$past(reset) |-> recalExclude == ($past(aboveNoise) & ~{NCH{$past(ctrlSh[5])}}))
        else $error("recalibration exclusion wrong");
endmodule
bind touch_global_config touch_global_config_chk #(.NCH(NCH), .MS_CYCLES(MS_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) chk_i (
    .clk, .reset, .regAddr, .regWrEn, .regWrData, .regRdData, .scl, .sda, .deepSleep, .foreignAbort,
    .busTimeout, .busIdleReset, .busIgnore, .lfNoise, .aboveNoise, .touchDetect, .calRetry,
    .recalExclude, .buttonPressed, .buttonIrq, .buttonRecal
);
`default_nettype wire

// File: bench/touch_global_config_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module touch_global_config_tb_top;
    logic clk, reset = 1'h1, deepSleep = 1'h0, sliderTouchValid = 1'h0, posWrEn = 1'h0;
    logic buttonPressed = 1'h0, groupHeld = 1'h0;
    logic [15:0] deltaCounts = 16'h0000, threshold = 16'h0000, baseRaw = 16'hFFFF;
    logic [1:0] lfNoise = 2'h0, aboveNoise = 2'h0;
    logic [6:0] sliderTouchPos = 7'h15, posWrData = 7'h2A;
    logic [3:0] buttonRepeatRate = 4'h0, groupRepeatRate = 4'h0, buttonHoldLimit = 4'h0, groupHoldLimit = 4'h0;
    wire logic [7:0] regAddr, regWrData, regRdData;
    wire logic regWrEn, scl, sda, foreignAbort, busTimeout, busIdleReset, busIgnore;
    wire logic buttonIrq, groupIrq, buttonRecal, groupRecal;
    wire logic [1:0] touchDetect, calRetry, recalExclude;
    wire logic [15:0] basePresented;
    wire logic [6:0] sliderPos;
    int n_mismatch = 0, total_checks = 0, cyc = 0, nIdle, nTmo, nBi, nGi, nBr, nGr;
    smb_host_model host (.clk, .regAddr, .regWrEn, .regWrData, .scl, .sda, .foreignAbort);
    touch_global_config #(.NCH(2), .MS_CYCLES(10), .IDLE_CYCLES(20)) DUT (
        .clk, .reset, .regAddr, .regWrEn, .regWrData, .regRdData, .scl, .sda, .deepSleep, .foreignAbort,
        .busTimeout, .busIdleReset, .busIgnore, .deltaCounts, .threshold, .lfNoise, .aboveNoise,
        .touchDetect, .calRetry, .recalExclude, .baseRaw, .basePresented, .sliderTouchPos,
        .sliderTouchValid, .posWrEn, .posWrData, .sliderPos, .buttonPressed, .groupHeld,
        .buttonRepeatRate, .groupRepeatRate, .button_hold_limit(buttonHoldLimit), .group_hold_limit(groupHoldLimit),
        .buttonIrq, .groupIrq, .buttonRecal, .groupRecal
    );
    // Clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            results;
        end
    end
    // Compare and count
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Count output pulses over n cycles
    task watch(input int n);
        {nIdle, nTmo, nBi, nGi, nBr, nGr} = 192'h0;
        repeat (n) begin
            @(negedge clk);
            nIdle += busIdleReset;
            nTmo += busTimeout;
            nBi += buttonIrq;
            nGi += groupIrq;
            nBr += buttonRecal;
            nGr += groupRecal;
        end
    endtask
    // Apply deltas and threshold, check both channels
    task det(input logic [15:0] d, input logic [15:0] t, input logic [1:0] e);
        deltaCounts = d;
        threshold = t;
        tick(2);
        chk("touch", touchDetect, e);
    endtask
    task t_regs;
        host.sel(8'h1F);
        chk("sens", regRdData, 8'h2F);
        host.sel(8'h20);
        chk("ctrl", regRdData, 8'h29);
        host.wr(8'h1F, 8'hFF);
        host.wr(8'h44, 8'h00);
        host.sel(8'h1F);
        chk("sens7", regRdData, 8'h7F);
        $display("t_regs done");
    endtask
    task t_sense;
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h1F, {1'h0, c[2:0], 4'h0});
            det(16'h0101, 16'h0001 << (7 - c), 2'h3);
            det(16'h0101, (16'h0001 << (7 - c)) + 16'h0001, 2'h0);
        end
        host.wr(8'h1F, 8'h00);
        det(16'h7F7F, 16'h3F80, 2'h3);
        det(16'hFF7F, 16'h3F80, 2'h1);
        $display("t_sense done");
    endtask
    task t_base;
        for (int c = 0; c < 16; c++) begin
            host.wr(8'h1F, {4'h0, c[3:0]});
            baseRaw = 16'hC3A5 ^ {c[3:0], 12'h000};
            det(16'h0101, 16'h0080, 2'h3);
            chk("base", basePresented, (16'hC3A5 ^ {c[3:0], 12'h000}) >> ((c > 8) ? 8 : c));
        end
        $display("t_base done");
    endtask
    task t_noise;
        host.wr(8'h20, 8'h00);
        host.wr(8'h1F, 8'h70);
        lfNoise = 2'h1;
        aboveNoise = 2'h2;
        det(16'h0101, 16'h0001, 2'h2);
        chk("retry", calRetry, 2'h1);
        chk("excl", recalExclude, 2'h2);
        host.wr(8'h20, 8'h30);
        det(16'h0101, 16'h0001, 2'h3);
        chk("retry", calRetry, 2'h0);
        chk("excl", recalExclude, 2'h0);
        lfNoise = 2'h0;
        $display("t_noise done");
    endtask
    task t_slider;
        sliderTouchValid = 1'h1;
        posWrEn = 1'h1;
        tick(2);
        chk("pos", sliderPos, 7'h15);
        sliderTouchPos = 7'h33;
        tick(2);
        chk("pos2", sliderPos, 7'h33);
        host.wr(8'h20, 8'h40);
        tick(2);
        chk("vol", sliderPos, 7'h2A);
        posWrData = 7'h55;
        tick(2);
        chk("vol2", sliderPos, 7'h55);
        posWrEn = 1'h0;
        sliderTouchValid = 1'h0;
        $display("t_slider done");
    endtask
    task t_bus;
        watch(60);
        chk("idleOff", nIdle, 16'h0);
        host.lines(1'h0, 1'h1);
        watch(400);
        chk("tmoOff", nTmo, 16'h0);
        host.wr(8'h20, 8'h80);
        host.lines(1'h1, 1'h1);
        watch(18);
        chk("idleEarly", nIdle, 16'h0);
        watch(22);
        chk("idle", nIdle, 16'h1);
        host.lines(1'h0, 1'h1);
        watch(295);
        chk("tmoEarly", nTmo, 16'h0);
        watch(30);
        chk("tmo", nTmo, 16'h1);
        deepSleep = 1'h1;
        host.lines(1'h1, 1'h1);
        watch(40);
        chk("idleSleep", nIdle, 16'h0);
        host.abort;
        chk("ignore", busIgnore, 1'h1);
        host.stop;
        tick(3);
        chk("ignoreEnd", busIgnore, 1'h0);
        deepSleep = 1'h0;
        $display("t_bus done");
    endtask
    // Hold both presses for 600 ms
    task hold(input logic [7:0] cfg);
        host.wr(8'h20, cfg);
        buttonPressed = 1'h1;
        groupHeld = 1'h1;
        watch(6000);
        buttonPressed = 1'h0;
        groupHeld = 1'h0;
        tick(3);
    endtask
    task t_hold;
        hold(8'h29);
        chk("btnIrq", nBi, 16'h1);
        chk("btnRecal", nBr, 16'h1);
        chk("grpRecal", nGr, 16'h0);
        chk("grpRepeat", nGi > 14 && nGi < 20, 1'h1);
        hold(8'h26);
        chk("btnRepeat", nBi > 14 && nBi < 20, 1'h1);
        chk("btnRecal", nBr, 16'h0);
        chk("grpIrq", nGi, 16'h1);
        chk("grpRecal", nGr, 16'h1);
        buttonRepeatRate = 4'h3;
        groupRepeatRate = 4'hF;
        buttonHoldLimit = 4'h1;
        groupHoldLimit = 4'h1;
        hold(8'h2F);
        chk("btnRate", nBi, 16'h5);
        chk("grpRate", nGi, 16'h2);
        chk("btnLimit", nBr, 16'h0);
        chk("grpLimit", nGr, 16'h0);
        $display("t_hold done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'h0;
        t_regs;
        t_sense;
        t_base;
        t_noise;
        t_slider;
        t_bus;
        t_hold;
        results;
    end
endmodule
`default_nettype wire

// File: rtl/bus_watchdog.v
`timescale 1ns/10ps
`default_nettype none
`include "touch_cfg_defs.vh"

module bus_watchdog #(
    parameter IDLE_CYCLES = `SMB_IDLE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Serial lines and millisecond tick
    input wire scl,
    input wire sda,
    input wire msTick,
    // Control
    input wire timeoutEn,
    input wire deepSleep,
    input wire foreignAbort,
    // Results
    output reg busTimeout,
    output reg busIdleReset,
    output reg busIgnore
);

reg [5:0] lowMs_reg;
reg [15:0] idleCnt_reg;
reg sdaPrev_reg;
wire stopSeen;

// Stop condition: data rises while clock high
assign stopSeen = scl & sda & ~sdaPrev_reg;

always @(posedge clk) begin
    if (reset) begin
        lowMs_reg <= 6'h00;
        busTimeout <= 1'b0;
    end else begin
        busTimeout <= 1'b0;
        if (!timeoutEn || scl) begin
            lowMs_reg <= 6'h00;
        end else if (msTick && lowMs_reg <= 6'd`SMB_TIMEOUT_MS) begin
            lowMs_reg <= lowMs_reg + 6'h01;
            busTimeout <= (lowMs_reg == 6'd`SMB_TIMEOUT_MS);
        end
    end
end

// both lines high too long resets protocol
// idle reset off in deep sleep
always @(posedge clk) begin
    if (reset) begin
        idleCnt_reg <= 16'h0000;
        busIdleReset <= 1'b0;
    end else begin
        busIdleReset <= 1'b0;
        if (!timeoutEn || deepSleep || !scl || !sda) begin
            idleCnt_reg <= 16'h0000;
        end else if (idleCnt_reg <= IDLE_CYCLES[15:0]) begin
            idleCnt_reg <= idleCnt_reg + 16'h0001;
            busIdleReset <= (idleCnt_reg == IDLE_CYCLES[15:0]);
        end
    end
end

// ignore transfers until a stop, set wins
always @(posedge clk) begin
    if (reset) begin
        sdaPrev_reg <= 1'b1;
        busIgnore <= 1'b0;
    end else begin
        sdaPrev_reg <= sda;
        if (deepSleep && foreignAbort) begin
            busIgnore <= 1'b1;
        end else if (stopSeen) begin
            busIgnore <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// File: rtl/hold_tracker.v
`timescale 1ns/10ps
`default_nettype none
`include "touch_cfg_defs.vh"

module hold_tracker (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Press state and millisecond tick
    input wire pressed,
    input wire msTick,
    // Settings
    input wire repeatEn,
    input wire [3:0] repeatCode,
    input wire holdEn,
    input wire [13:0] holdLimitMs,
    // Events
    output reg irqPulse,
    output reg recalPulse
);

reg pressPrev_reg;
reg [13:0] holdMs_reg;
reg [9:0] repMs_reg;
reg recalDone_reg;
wire [9:0] repPeriod;

// Repeat period is (code + 1) steps
assign repPeriod = ({6'h00, repeatCode} + 10'h001) * 10'd`REPEAT_STEP_MS;

// Press edge, repeat and hold-limit timing
always @(posedge clk) begin
    if (reset) begin
        pressPrev_reg <= 1'b0;
        holdMs_reg <= 14'h0000;
        repMs_reg <= 10'h000;
        recalDone_reg <= 1'b0;
        irqPulse <= 1'b0;
        recalPulse <= 1'b0;
    end else begin
        pressPrev_reg <= pressed;
        irqPulse <= 1'b0;
        recalPulse <= 1'b0;
        if (!pressed) begin
            holdMs_reg <= 14'h0000;
            repMs_reg <= 10'h000;
            recalDone_reg <= 1'b0;
        end else if (!pressPrev_reg) begin
            // One interrupt per new press
            irqPulse <= 1'b1;
        end else if (msTick) begin
            if (holdMs_reg != 14'h3FFF) begin
                holdMs_reg <= holdMs_reg + 14'h0001;
            end
            // Hold past limit restarts recalibration once
            if (holdEn && !recalDone_reg && holdMs_reg >= holdLimitMs) begin
                recalPulse <= 1'b1;
                recalDone_reg <= 1'b1;
            end
            // Repeat interrupts while held
            if (repeatEn && repMs_reg + 10'h001 >= repPeriod) begin
                irqPulse <= 1'b1;
                repMs_reg <= 10'h000;
            end else if (repeatEn) begin
                repMs_reg <= repMs_reg + 10'h001;
            end else begin
                repMs_reg <= 10'h000;
            end
        end
    end
end

endmodule
`default_nettype wire

// File: rtl/touch_cfg_defs.vh
`ifndef TOUCH_CFG_DEFS_VH
`define TOUCH_CFG_DEFS_VH

// Register offsets and reset values
`define SENS_ADDR 8'h1F
`define CTRL_ADDR 8'h20
`define SENS_RESET 8'h2F
`define CTRL_RESET 8'h29

// Sensitivity register fields
`define DELTA_HI 6
`define DELTA_LO 4
`define BASE_HI 3
`define BASE_LO 0
`define SENS_WMASK 8'h7F
`define BASE_MAX_CODE 4'h8

// Control register bit positions
`define TIMEOUT_BIT 7
`define POSMODE_BIT 6
`define DIGNOISE_BIT 5
`define ANANOISE_BIT 4
`define BHOLD_BIT 3
`define BREPEAT_BIT 2
`define GHOLD_BIT 1
`define GREPEAT_BIT 0

// Delta count saturation limits
`define DELTA_POS_MAX 8'h7F
`define DELTA_NEG_MAX 8'hFF

// Timing
`define CLK_PERIOD_NS 8
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define SMB_TIMEOUT_MS 30
`define SMB_IDLE_NS 150000
`define SMB_IDLE_CYCLES ((`SMB_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REPEAT_STEP_MS 35

`endif

// File: rtl/touch_global_config.v
`timescale 1ns/10ps
`default_nettype none
`include "touch_cfg_defs.vh"

module touch_global_config #(
    parameter NCH = 14,
    parameter BASE_W = 16,
    parameter MS_CYCLES = `MS_CYCLES,
    parameter IDLE_CYCLES = `SMB_IDLE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire reset,

    // Register access from the serial protocol engine
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData,

    // Serial lines and protocol state
    input wire scl,
    input wire sda,
    input wire deepSleep,
    input wire foreignAbort,
    output wire busTimeout,
    output wire busIdleReset,
    output wire busIgnore,

    // Per-channel sensing
    input wire [8*NCH-1:0] deltaCounts,
    input wire [15:0] threshold,
    input wire [NCH-1:0] lfNoise,
    input wire [NCH-1:0] aboveNoise,
    output reg [NCH-1:0] touchDetect,
    output reg [NCH-1:0] calRetry,
    output reg [NCH-1:0] recalExclude,

    // Base count presentation
    input wire [BASE_W-1:0] baseRaw,
    output reg [BASE_W-1:0] basePresented,

    // Slider position
    input wire [6:0] sliderTouchPos,
    input wire sliderTouchValid,
    input wire posWrEn,
    input wire [6:0] posWrData,
    output reg [6:0] sliderPos,

    // Press state and timing settings
    input wire buttonPressed,
    input wire groupHeld,
    input wire [3:0] buttonRepeatRate,
    input wire [3:0] groupRepeatRate,
    input wire [3:0] button_hold_limit,
    input wire [3:0] group_hold_limit,

    // Events
    output wire buttonIrq,
    output wire groupIrq,
    output wire buttonRecal,
    output wire groupRecal
);

// Stored register contents
reg [7:0] sens_reg;
reg [7:0] ctrl_reg;

// Shared millisecond timebase
reg [16:0] msCnt_reg;
reg msTick_reg;

// Detection working values, rebuilt every cycle
reg [NCH-1:0] touch_next;
reg [NCH-1:0] retry_next;
reg [NCH-1:0] excl_next;
reg signed [15:0] scaled;
reg [7:0] deltaByte;
// Channel index for the detection loop
integer i;

// Sensitivity fields
wire [2:0] deltaCode;
wire [3:0] baseCode;
wire [3:0] baseShift;

// Control bits by name
wire timeoutEn;
wire slider_report_mode;
wire digital_noise_ignore;
wire analog_noise_ignore;
wire button_hold_recal_en;
wire button_repeat_en;
wire group_hold_recal_en;
wire group_repeat_en;

// Control bit fan-out
// Named wires keep each enable traceable to its bit
assign timeoutEn = ctrl_reg[`TIMEOUT_BIT];
assign slider_report_mode = ctrl_reg[`POSMODE_BIT];
assign digital_noise_ignore = ctrl_reg[`DIGNOISE_BIT];
assign analog_noise_ignore = ctrl_reg[`ANANOISE_BIT];
assign button_hold_recal_en = ctrl_reg[`BHOLD_BIT];
assign button_repeat_en = ctrl_reg[`BREPEAT_BIT];
assign group_hold_recal_en = ctrl_reg[`GHOLD_BIT];
assign group_repeat_en = ctrl_reg[`GREPEAT_BIT];

// Shared sensitivity fields
// Every channel decodes the same delta field; the base field sets the one presented count
assign deltaCode = sens_reg[`DELTA_HI:`DELTA_LO];
assign baseCode = sens_reg[`BASE_HI:`BASE_LO];

// Without the clamp a shift of 15 would leave almost nothing
// base codes above 8 clamp to 256x
assign baseShift = (baseCode > `BASE_MAX_CODE) ? `BASE_MAX_CODE : baseCode;

// Hold limit code to milliseconds
// The steps are not uniform, so a lookup table is used
// Code D is 8906 ms, not a multiple of 560 ms
function [13:0] holdMs;
    input [3:0] code;
    begin
        case (code)
            4'h0: holdMs = 14'd560;
            4'h1: holdMs = 14'd840;
            4'h2: holdMs = 14'd1120;
            4'h3: holdMs = 14'd1400;
            4'h4: holdMs = 14'd1680;
            4'h5: holdMs = 14'd2240;
            4'h6: holdMs = 14'd2800;
            4'h7: holdMs = 14'd3360;
            4'h8: holdMs = 14'd3920;
            4'h9: holdMs = 14'd4480;
            4'hA: holdMs = 14'd5600;
            4'hB: holdMs = 14'd6720;
            4'hC: holdMs = 14'd7840;
            4'hD: holdMs = 14'd8906;
            4'hE: holdMs = 14'd10080;
            default: holdMs = 14'd11200;
        endcase
    end
endfunction

// Largest product is 7Fh shifted by 7, which still fits 16 bits
// multiplier is 128 >> code, so shift left by 7 - code
function signed [15:0] scaleDelta;
    input [7:0] delta;
    input [2:0] code;
    reg signed [15:0] ext;
    begin
        ext = {{8{delta[7]}}, delta};
        scaleDelta = ext <<< (3'h7 - code);
    end
endfunction

// Register writes
// Both registers share one decoder, so a write lands in one cycle
// bit 7 of sensitivity never stored
always @(posedge clk) begin
    if (reset) begin
        sens_reg <= `SENS_RESET;
        ctrl_reg <= `CTRL_RESET;
    end else if (regWrEn) begin
        if (regAddr == `SENS_ADDR) begin
            sens_reg <= regWrData & `SENS_WMASK;
        end
        if (regAddr == `CTRL_ADDR) begin
            ctrl_reg <= regWrData;
        end
    end
end

// Register reads; other addresses belong elsewhere and read zero
// Bit 7 is masked again so a stray stored one can never show
always @* begin
    case (regAddr)
        `SENS_ADDR: regRdData = sens_reg & `SENS_WMASK;
        `CTRL_ADDR: regRdData = ctrl_reg;
        default: regRdData = 8'h00;
    endcase
end

// Millisecond tick for all long timers
// Free running, so a long timer may start up to one tick late;
// one shared divider is far cheaper than a divider per timer
// and keeps every timer on the same phase
always @(posedge clk) begin
    if (reset) begin
        msCnt_reg <= 17'h00000;
        msTick_reg <= 1'b0;
    end else if (msCnt_reg == MS_CYCLES[16:0] - 17'h00001) begin
        msCnt_reg <= 17'h00000;
        msTick_reg <= 1'b1;
    end else begin
        msCnt_reg <= msCnt_reg + 17'h00001;
        msTick_reg <= 1'b0;
    end
end

// Per-channel detection and noise handling
// Negative deltas never count as a touch, whatever the threshold
always @* begin
    touch_next = {NCH{1'b0}};
    retry_next = {NCH{1'b0}};
    excl_next = {NCH{1'b0}};
    scaled = 16'sh0000;
    deltaByte = 8'h00;
    for (i = 0; i < NCH; i = i + 1) begin
        // delta byte arrives saturated two's complement
        deltaByte = deltaCounts[8*i +: 8];
        scaled = scaleDelta(deltaByte, deltaCode);
        touch_next[i] = (scaled >= $signed(threshold)) && !deltaByte[7];
        // Retry is raised only for low-frequency noise while the analog noise bit is clear
        // low-frequency noise blocks touch and retries
        // ignored when analog noise bit set
        if (lfNoise[i] && !analog_noise_ignore) begin
            touch_next[i] = 1'b0;
            retry_next[i] = 1'b1;
        end
        // noisy samples kept out of recalibration
        excl_next[i] = aboveNoise[i] && !digital_noise_ignore;
    end
end

// Registered detection outputs
// One cycle of latency keeps all three outputs aligned
always @(posedge clk) begin
    if (reset) begin
        touchDetect <= {NCH{1'b0}};
        calRetry <= {NCH{1'b0}};
        recalExclude <= {NCH{1'b0}};
    end else begin
        touchDetect <= touch_next;
        calRetry <= retry_next;
        recalExclude <= excl_next;
    end
end

// A stale shift only affects reading, never a touch decision
// presented base count shifted by scaling factor
// separate path, detection never sees it
always @(posedge clk) begin
    if (reset) begin
        basePresented <= {BASE_W{1'b0}};
    end else begin
        basePresented <= baseRaw >> baseShift;
    end
end

// Host writes are dropped while the report mode bit is clear; then touch positions are taken
// slider position source follows report mode
always @(posedge clk) begin
    if (reset) begin
        sliderPos <= 7'h00;
    end else if (slider_report_mode) begin
        if (posWrEn) begin
            sliderPos <= posWrData;
        end
    end else if (sliderTouchValid) begin
        sliderPos <= sliderTouchPos;
    end
end

// The watchdog shares the millisecond tick with the trackers
// Its pulses are one cycle wide; the protocol engine acts on them
// watchdog timeout and idle reset gated by timeout bit, ignore is not
bus_watchdog #(
    .IDLE_CYCLES(IDLE_CYCLES)
) watchdog (
    .clk(clk),
    .reset(reset),
    .scl(scl),
    .sda(sda),
    .msTick(msTick_reg),
    .timeoutEn(timeoutEn),
    .deepSleep(deepSleep),
    .foreignAbort(foreignAbort),
    .busTimeout(busTimeout),
    .busIdleReset(busIdleReset),
    .busIgnore(busIgnore)
);

// Ungrouped buttons share one tracker
// button hold recalibration
hold_tracker buttonTrack (
    .clk(clk),
    .reset(reset),
    .pressed(buttonPressed),
    .msTick(msTick_reg),
    .repeatEn(button_repeat_en),
    .repeatCode(buttonRepeatRate),
    .holdEn(button_hold_recal_en),
    .holdLimitMs(holdMs(button_hold_limit)),
    .irqPulse(buttonIrq),
    .recalPulse(buttonRecal)
);

// The grouped press-and-hold condition drives this tracker
// group hold recalibration
hold_tracker groupTrack (
    .clk(clk),
    .reset(reset),
    .pressed(groupHeld),
    .msTick(msTick_reg),
    .repeatEn(group_repeat_en),
    .repeatCode(groupRepeatRate),
    .holdEn(group_hold_recal_en),
    .holdLimitMs(holdMs(group_hold_limit)),
    .irqPulse(groupIrq),
    .recalPulse(groupRecal)
);

endmodule
`default_nettype wire
